// ### design/synth_synth_control_word_and_symbol_rate_regs.sv
// Frequency word and symbol rate registers with rate generator
//
// Notes on behaviour
// - Top two frequency word bits fixed at 01.
// - Base word is high, middle, low bytes.
// - Exponent register upper nibble reserved, reads zero.
// - Exponent held in low nibble, read/write.
// - Mantissa nine bits, top bit implied one.
// - Rate is (256+M)*2^E/2^28 of clock.
// - Carrier adds channel times spacing to base.
`include "synth_regs_cfg.svh"
`default_nettype none

module synth_synth_control_word_and_symbol_rate_regs #(
  parameter int SPACING_W = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire synth_regs_pkg::reg_request_type reg_request,
  input wire logic [7:0] channel_index,
  input wire logic [SPACING_W-1:0] channel_spacing,
  output logic [7:0] reg_read_data,
  output logic reg_read_valid,
  output logic [23:0] synth_control_word,
  output logic [3:0] symbol_rate_exponent,
  output logic [8:0] symbol_rate_mantissa,
  output logic symbol_tick,
  output logic [31:0] carrier_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  // Channel index is 8 bits, so spacing above 24 bits overflows the carrier
  if (SPACING_W < 1 || SPACING_W > 24) begin : bad_spacing
    $error("SPACING_W must lie between 1 and 24");
  end

  // The fixed bits and the writable field must tile the high byte
  if (`SYNTH_FIXED_MSB != 7 ||
      `SYNTH_FIXED_LSB != `SYNTH_HIGH_FIELD_MSB + 1 ||
      `SYNTH_HIGH_FIELD_LSB != 0) begin : bad_high_layout
    $error("High byte fields must tile bits 7 to 0");
  end

  // The reserved nibble and the exponent must tile the exponent byte
  if (`RATE_RESERVED_MSB != 7 ||
      `RATE_RESERVED_LSB != `RATE_EXPONENT_MSB + 1 ||
      `RATE_EXPONENT_LSB != 0) begin : bad_rate_layout
    $error("Exponent byte fields must tile bits 7 to 0");
  end

  // Fixed and reset values must match the widths of their fields
  if ($bits(`SYNTH_FIXED_VALUE) !=
      `SYNTH_FIXED_MSB - `SYNTH_FIXED_LSB + 1) begin : bad_fixed_w
    $error("Fixed frequency bits value has the wrong width");
  end
  if ($bits(`SYNTH_HIGH_RESET) !=
      `SYNTH_HIGH_FIELD_MSB - `SYNTH_HIGH_FIELD_LSB + 1) begin : bad_high_w
    $error("High field reset value has the wrong width");
  end
  if ($bits(`RATE_RESERVED_VALUE) !=
      `RATE_RESERVED_MSB - `RATE_RESERVED_LSB + 1) begin : bad_resv_w
    $error("Reserved nibble value has the wrong width");
  end
  if ($bits(`RATE_EXPONENT_RESET) !=
      `RATE_EXPONENT_MSB - `RATE_EXPONENT_LSB + 1) begin : bad_exp_w
    $error("Exponent reset value has the wrong width");
  end

  // Phase register is 28 bits; a step of 511 << 15 stays below half of it,
  // so a tick never lasts two cycles
  if (`RATE_FRACTION_BITS != 28) begin : bad_fraction
    $error("Rate fraction must be 28 bits wide");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  synth_regs_pkg::state_type state;
  synth_regs_pkg::state_type next_state;

  // Reset images of the decoded outputs
  localparam logic [23:0] BASE_WORD_RESET = {`SYNTH_FIXED_VALUE,
    `SYNTH_HIGH_RESET, `SYNTH_MIDDLE_RESET, `SYNTH_LOW_RESET};
  localparam logic [8:0] MANTISSA_RESET = {`RATE_HIDDEN_ONE,
    `RATE_MANTISSA_RESET};

  logic [23:0] base_word;
  logic [8:0] full_mantissa;
  logic [23:0] rate_increment;
  logic [28:0] phase_sum;
  logic [31:0] channel_offset;

  ////////////////////////////////////////////////////////////////////////////
  // Derived values

  always_comb begin
    // Top two bits are wired, never stored, so writes cannot reach them
    base_word = {`SYNTH_FIXED_VALUE, state.synth_high,
                 state.synth_middle, state.synth_low};
    // Only eight mantissa bits are stored; the ninth is the hidden one
    full_mantissa = {`RATE_HIDDEN_ONE, state.rate_mantissa};
    // (256 + M) * 2^E; at most 511 * 2^15, fits in 24 bits
    rate_increment = 24'(full_mantissa) << state.rate_exponent;
    // Carry out of the 2^28 fraction is one symbol; ticks average
    // clock * (256 + M) * 2^E / 2^28 and are spread, never bunched
    phase_sum = {1'b0, state.rate_phase}
                + 29'(rate_increment);
    // Product of the 8-bit index and the spacing fits in 32 bits
    channel_offset = 32'(channel_index)
                     * 32'(channel_spacing);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_state = state;

    // Register writes; fixed and reserved bits are simply not stored
    if (reg_request.write) begin
      unique case (reg_request.addr)
        `SYNTH_WORD_HIGH_ADDR: begin
          next_state.synth_high = reg_request.wdata[
            `SYNTH_HIGH_FIELD_MSB:`SYNTH_HIGH_FIELD_LSB];
        end
        `SYNTH_WORD_MIDDLE_ADDR: begin
          next_state.synth_middle = reg_request.wdata;
        end
        `SYNTH_WORD_LOW_ADDR: begin
          next_state.synth_low = reg_request.wdata;
        end
        `RATE_EXPONENT_CONFIG_ADDR: begin
          next_state.rate_exponent = reg_request.wdata[
            `RATE_EXPONENT_MSB:`RATE_EXPONENT_LSB];
        end
        `RATE_MANTISSA_CONFIG_ADDR: begin
          next_state.rate_mantissa = reg_request.wdata;
        end
        default: begin
        end
      endcase
    end

    // Register reads answer one cycle after the strobe
    // A write and a read of one register in one cycle return the old value
    next_state.read_valid = reg_request.read;
    if (reg_request.read) begin
      unique case (reg_request.addr)
        `SYNTH_WORD_HIGH_ADDR: begin
          next_state.read_data = {`SYNTH_FIXED_VALUE,
                                  state.synth_high};
        end
        `SYNTH_WORD_MIDDLE_ADDR: begin
          next_state.read_data = state.synth_middle;
        end
        `SYNTH_WORD_LOW_ADDR: begin
          next_state.read_data = state.synth_low;
        end
        `RATE_EXPONENT_CONFIG_ADDR: begin
          next_state.read_data = {`RATE_RESERVED_VALUE,
                                  state.rate_exponent};
        end
        `RATE_MANTISSA_CONFIG_ADDR: begin
          next_state.read_data = state.rate_mantissa;
        end
        default: begin
          next_state.read_data = `UNMAPPED_READ_VALUE;
        end
      endcase
    end

    // Symbol rate phase accumulator
    next_state.rate_phase = phase_sum[27:0];
    next_state.symbol_tick = phase_sum[28];

    // Decoded values to the synthesiser and modulator
    // They lag the stored registers by one cycle
    next_state.synth_control_word = base_word;
    next_state.symbol_rate_exponent = state.rate_exponent;
    next_state.symbol_rate_mantissa = full_mantissa;
    next_state.carrier_word = 32'(base_word) + channel_offset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state.synth_high <= `SYNTH_HIGH_RESET;
      state.synth_middle <= `SYNTH_MIDDLE_RESET;
      state.synth_low <= `SYNTH_LOW_RESET;
      state.rate_exponent <= `RATE_EXPONENT_RESET;
      state.rate_mantissa <= `RATE_MANTISSA_RESET;
      state.read_data <= 8'h00;
      state.read_valid <= 1'b0;
      state.rate_phase <= 28'h0000000;
      state.symbol_tick <= 1'b0;
      state.synth_control_word <= BASE_WORD_RESET;
      state.symbol_rate_exponent <= `RATE_EXPONENT_RESET;
      state.symbol_rate_mantissa <= MANTISSA_RESET;
      state.carrier_word <= 32'h00000000;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every output comes straight from the state register
  assign reg_read_data = state.read_data;
  assign reg_read_valid = state.read_valid;
  assign synth_control_word = state.synth_control_word;
  assign symbol_rate_exponent = state.symbol_rate_exponent;
  assign symbol_rate_mantissa = state.symbol_rate_mantissa;
  assign symbol_tick = state.symbol_tick;
  assign carrier_word = state.carrier_word;

endmodule

`default_nettype wire

// ### design/synth_regs_cfg.svh
// Offsets, field positions, reset values and fixed figures of the register bank
`ifndef SYNTH_REGS_CFG_SVH
`define SYNTH_REGS_CFG_SVH

// Register offsets on the serial register port
`define SYNTH_WORD_HIGH_ADDR 6'h0D
`define SYNTH_WORD_MIDDLE_ADDR 6'h0E
`define SYNTH_WORD_LOW_ADDR 6'h0F
`define RATE_EXPONENT_CONFIG_ADDR 6'h10
`define RATE_MANTISSA_CONFIG_ADDR 6'h11

// Field positions
`define SYNTH_FIXED_MSB 7
`define SYNTH_FIXED_LSB 6
`define SYNTH_HIGH_FIELD_MSB 5
`define SYNTH_HIGH_FIELD_LSB 0
`define RATE_RESERVED_MSB 7
`define RATE_RESERVED_LSB 4
`define RATE_EXPONENT_MSB 3
`define RATE_EXPONENT_LSB 0

// Fixed and reset values
`define SYNTH_FIXED_VALUE 2'h1
`define SYNTH_HIGH_RESET 6'h1E
`define SYNTH_MIDDLE_RESET 8'hC4
`define SYNTH_LOW_RESET 8'hEC
`define RATE_RESERVED_VALUE 4'h0
`define RATE_EXPONENT_RESET 4'hC
`define RATE_MANTISSA_RESET 8'h22
`define UNMAPPED_READ_VALUE 8'h00

// Symbol rate arithmetic: hidden mantissa bit and fraction width 2^28
`define RATE_HIDDEN_ONE 1'h1
`define RATE_FRACTION_BITS 28
// Synthesiser word step is crystal_frequency / 2^16
`define SYNTH_STEP_SHIFT 16

`endif

// ### design/synth_regs_pkg.sv
// Types shared by the frequency and symbol rate register bank
`default_nettype none

package synth_regs_pkg;

  // One access on the serial register port
  typedef struct packed {
    logic [5:0] addr;
    logic write;
    logic read;
    logic [7:0] wdata;
  } reg_request_type;

  // Whole state of the register bank
  typedef struct packed {
    logic [5:0] synth_high;
    logic [7:0] synth_middle;
    logic [7:0] synth_low;
    logic [3:0] rate_exponent;
    logic [7:0] rate_mantissa;
    logic [7:0] read_data;
    logic read_valid;
    logic [27:0] rate_phase;
    logic symbol_tick;
    logic [23:0] synth_control_word;
    logic [3:0] symbol_rate_exponent;
    logic [8:0] symbol_rate_mantissa;
    logic [31:0] carrier_word;
  } state_type;

endpackage

`default_nettype wire

// ### tb/synth_regs_checker.sv
// Port assertions for the frequency and symbol rate register bank
`include "synth_regs_cfg.svh"
`default_nettype none
module synth_regs_checker #(
  parameter int SPACING_W = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire synth_regs_pkg::reg_request_type reg_request,
  input wire logic [7:0] channel_index,
  input wire logic [SPACING_W-1:0] channel_spacing,
  input wire logic [7:0] reg_read_data,
  input wire logic reg_read_valid,
  input wire logic [23:0] synth_control_word,
  input wire logic [3:0] symbol_rate_exponent,
  input wire logic [8:0] symbol_rate_mantissa,
  input wire logic symbol_tick,
  input wire logic [31:0] carrier_word
);
  wire logic [5:0] a = reg_request.addr;
  wire logic w = reg_request.write;
  wire logic r = reg_request.read;
  wire logic [7:0] d = reg_request.wdata;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_fixed; synth_control_word[23:22] == 2'h1; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits");
  property p_mid;
    w && a == 6'h0E |-> ##2 synth_control_word[15:8] == $past(d, 2);
  endproperty
  a_mid: assert property (p_mid) else $error("middle byte");
  property p_resv; r && a == 6'h10 |=> reg_read_data[7:4] == 4'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits");
  property p_exp;
    w && a == 6'h10 |-> ##2 symbol_rate_exponent == $past(d[3:0], 2);
  endproperty
  a_exp: assert property (p_exp) else $error("exponent");
  property p_mant;
    w && a == 6'h11 |-> ##2 symbol_rate_mantissa == {1'b1, $past(d, 2)};
  endproperty
  a_mant: assert property (p_mant) else $error("mantissa");
  property p_tick; symbol_tick |=> !symbol_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick width");
  property p_car; $past(rst_n) |-> carrier_word ==
    synth_control_word + $past(channel_index) * $past(channel_spacing);
  endproperty
  a_car: assert property (p_car) else $error("carrier");
  property p_high; r && a == 6'h0D |=> reg_read_data[7:6] == 2'h1; endproperty
  a_high: assert property (p_high) else $error("high byte read");
  property p_rmid;
    r && a == 6'h0E |=> reg_read_data == synth_control_word[15:8];
  endproperty
  a_rmid: assert property (p_rmid) else $error("middle read");
  property p_valid; r |=> reg_read_valid; endproperty
  a_valid: assert property (p_valid) else $error("read answer");
  property p_quiet; !r |=> !reg_read_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
endmodule
bind synth_synth_control_word_and_symbol_rate_regs synth_regs_checker #(
  .SPACING_W(SPACING_W)
) u_synth_regs_checker (
  .clock(clock),
  .rst_n(rst_n),
  .reg_request(reg_request),
  .channel_index(channel_index),
  .channel_spacing(channel_spacing),
  .reg_read_data(reg_read_data),
  .reg_read_valid(reg_read_valid),
  .synth_control_word(synth_control_word),
  .symbol_rate_exponent(symbol_rate_exponent),
  .symbol_rate_mantissa(symbol_rate_mantissa),
  .symbol_tick(symbol_tick),
  .carrier_word(carrier_word)
);
`default_nettype wire

// ### tb/host_model.sv
// Host model driving register accesses on the strobe port
`default_nettype none
module host_model (
  input wire logic clock,
  output var synth_regs_pkg::reg_request_type reg_request,
  input wire logic [7:0] reg_read_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial reg_request = '0;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_request = '{a, 1'b1, 1'b0, d};
    @(negedge clock);
    reg_request = '{a, 1'b0, 1'b0, ~d};
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_request = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge clock);
    reg_request.read = 1'b0;
    d = reg_read_data;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Bench for the frequency and symbol rate register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] channel_index = 8'h03;
  logic [15:0] channel_spacing = 16'h0010;
  synth_regs_pkg::reg_request_type reg_request;
  logic [7:0] reg_read_data, v;
  logic reg_read_valid, symbol_tick;
  logic [23:0] synth_control_word;
  logic [3:0] symbol_rate_exponent;
  logic [8:0] symbol_rate_mantissa;
  logic [31:0] carrier_word;
  int n_errors = 0, check_count = 0, cycles = 0, gap = 0;
  // Offset, reset value, written value, value read back
  logic [31:0] rows [6] = '{32'h0D5EFF7F, 32'h0EC4AAAA, 32'h0FEC5555,
    32'h100CFF0F, 32'h11220000, 32'h2000FF00};
  synth_synth_control_word_and_symbol_rate_regs u_synth_synth_control_word_and_symbol_rate_regs (
    .clock(clock),
    .rst_n(rst_n),
    .reg_request(reg_request),
    .channel_index(channel_index),
    .channel_spacing(channel_spacing),
    .reg_read_data(reg_read_data),
    .reg_read_valid(reg_read_valid),
    .synth_control_word(synth_control_word),
    .symbol_rate_exponent(symbol_rate_exponent),
    .symbol_rate_mantissa(symbol_rate_mantissa),
    .symbol_tick(symbol_tick),
    .carrier_word(carrier_word)
  );
  host_model u_host_model (
    .clock(clock),
    .reg_request(reg_request),
    .reg_read_data(reg_read_data)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      u_host_model.rd(rows[i][29:24], v);
      chk(v, rows[i][23:16]);
      u_host_model.wr(rows[i][29:24], rows[i][15:8]);
      u_host_model.rd(rows[i][29:24], v);
      chk(v, rows[i][7:0]);
      chk(reg_read_valid, 1'b1);
    end
    chk(synth_control_word, 24'h7FAA55);
    chk(symbol_rate_exponent, 4'hF);
    chk(symbol_rate_mantissa, 9'h100);
    chk(carrier_word, 32'h007FAA85);
    while (symbol_tick !== 1'b1) begin
      @(negedge clock);
    end
    @(negedge clock);
    for (gap = 1; gap < 64 && symbol_tick !== 1'b1; gap++) begin
      @(negedge clock);
    end
    chk(gap, 32);
    // Carrier follows new channel inputs one cycle later
    channel_index = 8'hFF;
    channel_spacing = 16'hFFFF;
    @(negedge clock);
    chk(carrier_word, 32'h017EA956);
    // Reset in mid-run brings back every default
    rst_n = 1'b0;
    @(negedge clock);
    chk(synth_control_word, 24'h5EC4EC);
    chk(symbol_rate_exponent, 4'hC);
    chk(symbol_rate_mantissa, 9'h122);
    chk(carrier_word, 32'h00000000);
    chk({symbol_tick, reg_read_valid}, 2'h0);
    chk(reg_read_data, 8'h00);
    @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk(carrier_word, 32'h015DC3ED);
    foreach (rows[i]) begin
      u_host_model.rd(rows[i][29:24], v);
      chk(v, rows[i][23:16]);
    end
    close_out();
  end
endmodule
`default_nettype wire
